// ---- bench/spt_ext_src.sv ----
// Model of the external count clock source that drives the counter pin.
`default_nettype none
module spt_ext_src (
    input wire logic clk_i,
    output var logic ext_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Each level is held four device clocks, so both sampling phases see it.
    task automatic toggle(input int n);
        repeat (n) begin
            @(posedge clk_i);
            ext_o <= ~ext_o;
            repeat (3) @(posedge clk_i);
        end
    endtask
    // Parking the line low gives each scenario a known starting level.
    task automatic park();
        @(posedge clk_i);
        ext_o <= 1'b0;
    endtask
    initial ext_o = 1'b0;
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the shared-prescaler timer.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] cfg; logic [15:0] tog; logic [7:0] exp;} spt_row_t;
    logic clk, rst_n, ext, tick, hwrite, hready, hresp, ovf_o, wrst;
    logic [1:0] htrans;
    logic hsel;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [7:0] count;
    int err_count = 0, checked = 0, cyc = 0, ovf = 0;
    // Config, toggles from a low line, expected count; internal rows allow one count of slack.
    spt_row_t rows [8] = '{'{8'h38, 16'd5, 8'd2}, '{8'h28, 16'd5, 8'd3},
        '{8'h20, 16'd16, 8'd4}, '{8'h22, 16'd32, 8'd2}, '{8'h27, 16'd512, 8'd1},
        '{8'h2F, 16'd4, 8'd2}, '{8'h08, 16'd0, 8'd10}, '{8'h00, 16'd0, 8'd5}};
    spt_ext_src u_src (.clk_i(clk), .ext_o(ext));
    spt_timer #(.WDOG_W(4)) u_dut (.REF_CLK_I(clk), .RESETN_I(rst_n),
        .EXT_COUNT_INPUT_I(ext), .WDOG_TICK_I(tick), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
        .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
        .HRESP_O(hresp), .COUNT_O(count), .OVERFLOW_O(ovf_o), .WDOG_RESET_O(wrst));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // A hang is cut off well beyond the few thousand cycles the tests need.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (ovf_o === 1'b1) ovf <= ovf + 1;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // One single AHB-Lite transfer; read data lands in q at the end of the data phase.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        htrans <= spt_pkg::HTRANS_NONSEQ;
        hsel <= 1'b1;
        hsize <= spt_pkg::HSIZE_WORD;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk) tick <= 1'b1;
            @(posedge clk) tick <= 1'b0;
        end
    endtask
    initial begin
        {rst_n, tick, hwrite, htrans, haddr, hwdata, hsel, hsize} = '0;
        repeat (10) @(posedge clk);
        chk({hready, count}, {1'b1, 8'h00});
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, spt_pkg::ADDR_CONFIG, 0);
        chk(q, {24'h0, spt_pkg::CFG_RESET});
        bus(0, 8'h10, 0);
        chk(q, 32'h0);
        foreach (rows[i]) begin
            bus(1, spt_pkg::ADDR_CONFIG, {24'h0, rows[i].cfg});
            u_src.park();
            repeat (10) @(posedge clk);
            bus(1, spt_pkg::ADDR_COUNT, 32'h0);
            u_src.toggle(int'(rows[i].tog));
            repeat (40) @(posedge clk);
            bus(0, spt_pkg::ADDR_COUNT, 0);
            if (!rows[i].cfg[5] && q[7:0] + 8'h01 >= rows[i].exp && q[7:0] <= rows[i].exp + 8'h01)
                q = {24'h0, rows[i].exp};
            chk(q, {24'h0, rows[i].exp});
        end
        // A counter write in mid-division must drop the three edges already taken.
        bus(1, spt_pkg::ADDR_CONFIG, 32'h21);
        u_src.park();
        bus(1, spt_pkg::ADDR_COUNT, 32'h0);
        u_src.toggle(6);
        bus(1, spt_pkg::ADDR_COUNT, 32'h0);
        u_src.toggle(2);
        repeat (20) @(posedge clk);
        bus(0, spt_pkg::ADDR_COUNT, 0);
        chk(q, 32'h0);
        bus(0, spt_pkg::ADDR_CONFIG, 0);
        chk(q, 32'h21);
        u_src.toggle(6);
        repeat (20) @(posedge clk);
        bus(0, spt_pkg::ADDR_COUNT, 0);
        chk(q, 32'h1);
        // Rolling over from all-ones gives one overflow pulse.
        bus(1, spt_pkg::ADDR_CONFIG, 32'h28);
        bus(1, spt_pkg::ADDR_COUNT, 32'hFF);
        u_src.toggle(2);
        repeat (20) @(posedge clk);
        chk({count, 24'(ovf)}, {8'h00, 24'h1});
        // Watchdog at 1:2: 31 ticks stay short of a wrap only if the clear reset the prescaler.
        bus(1, spt_pkg::ADDR_WDOG_STATUS, 32'h1);
        bus(1, spt_pkg::ADDR_WDOG_CLEAR, 32'h0);
        bus(1, spt_pkg::ADDR_CONFIG, 32'h09);
        ticks(31);
        bus(1, spt_pkg::ADDR_WDOG_CLEAR, 32'h0);
        ticks(31);
        repeat (5) @(posedge clk);
        chk(wrst, 1'b0);
        ticks(1);
        repeat (5) @(posedge clk);
        chk(wrst, 1'b1);
        end_of_test();
    end
endmodule
`default_nettype wire

// ---- design/spt_pkg.sv ----
// Package with register map, field positions, reset values and timing constants of the timer.
`default_nettype none
package spt_pkg;
    // Byte addresses of the word-wide registers.
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_COUNT = 8'h04;
    localparam logic [7:0] ADDR_WDOG_CLEAR = 8'h08;
    localparam logic [7:0] ADDR_WDOG_STATUS = 8'h0C;
    localparam int ADDR_W = 8;
    // Configuration register fields.
    localparam int CFG_RATE_LSB = 0;
    localparam int CFG_RATE_MSB = 2;
    localparam int CFG_OWNER_BIT = 3;
    localparam int CFG_EDGE_BIT = 4;
    localparam int CFG_SRC_BIT = 5;
    localparam logic [7:0] CFG_RESET = 8'hFF;
    // Phase generator: four device clocks form one instruction cycle.
    localparam logic [1:0] PHASE_TWO = 2'h1;
    localparam logic [1:0] PHASE_FOUR = 2'h3;
    // Watchdog enable reset value and AHB-Lite transfer codes.
    localparam logic [7:0] WDOG_ENABLE_RESET = 8'h00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage
`default_nettype wire

// ---- design/spt_timer.sv ----
// Shared-prescaler eight-bit timer with watchdog, reached over AHB-Lite.
// Contract
// - External input sampled on phase two and phase four; raw when unprescaled.
// - One prescaler, owned by counter or watchdog; the other runs undivided.
// - Software can neither read nor write the prescaler count.
// - Ownership and ratio come from configuration bits three down to zero.
// - Ownership bit one gives prescaler to watchdog, zero to counter.
// - Counter write clears prescaler when counter owns it; ownership unchanged.
// - Watchdog clear clears prescaler and watchdog count when watchdog owns it.
// - Counter divide is 2^(n+1); watchdog divide is 2^n.
// - Edge bit one counts falling external edges, zero counts rising.
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`default_nettype none
module spt_timer #(
    parameter int WDOG_W = 18
) (
    input wire logic REF_CLK_I,
    input wire logic RESETN_I,
    input wire logic EXT_COUNT_INPUT_I,
    input wire logic WDOG_TICK_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    output logic [7:0] COUNT_O,
    output logic OVERFLOW_O,
    output logic WDOG_RESET_O
);
    // Bus address-phase capture and register state.
    logic wr_pend_r, wr_pend_nxt;
    logic [spt_pkg::ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [7:0] cfg_r, cfg_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [7:0] presc_r, presc_nxt;
    logic [WDOG_W-1:0] wdog_r, wdog_nxt;
    logic wdog_en_r, wdog_en_nxt;
    logic wdog_rst_r, wdog_rst_nxt;
    logic ovf_r, ovf_nxt;
    logic [1:0] phase_r, phase_nxt;
    logic ext_s1_r, ext_s2_r;
    logic samp_r, samp_nxt;
    logic src_prev_r, src_prev_nxt;

    logic addr_ok, owner_wdog, ext_level, edge_seen, cnt_wr, wd_clr;
    logic [7:0] presc_inc;
    logic [2:0] rate;
    logic tap_cnt, tap_wd, cnt_tick, wd_tick, instr_tick;

    // The pin is asynchronous, so two flops sit before anything reads it.
    always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
        end else begin
            ext_s1_r <= EXT_COUNT_INPUT_I;
            ext_s2_r <= ext_s1_r;
        end
    end

    assign addr_ok = HSEL_I && HREADY_I && (HTRANS_I == spt_pkg::HTRANS_NONSEQ);
    assign owner_wdog = cfg_r[spt_pkg::CFG_OWNER_BIT];
    assign rate = cfg_r[spt_pkg::CFG_RATE_MSB:spt_pkg::CFG_RATE_LSB];
    assign cnt_wr = wr_pend_r && (wr_addr_r == spt_pkg::ADDR_COUNT);
    assign wd_clr = wr_pend_r && (wr_addr_r == spt_pkg::ADDR_WDOG_CLEAR);
    assign instr_tick = (phase_r == spt_pkg::PHASE_FOUR);
    // Edge polarity is applied before the prescaler so both owners see one clean event.
    assign ext_level = ext_s2_r ^ cfg_r[spt_pkg::CFG_EDGE_BIT];

    // Source event into the counter path, one cycle wide.
    always_comb begin
        if (cfg_r[spt_pkg::CFG_SRC_BIT]) begin
            edge_seen = samp_r && !src_prev_r;
        end else begin
            edge_seen = instr_tick;
        end
    end

    // Prescaler taps: counter owner uses bit n (2^(n+1)), watchdog uses bit n-1 (2^n).
    // A tap fires when its bit falls, so the first output comes after a full period.
    assign presc_inc = presc_r + 8'h01;
    assign tap_cnt = presc_r[rate] && !presc_inc[rate];
    assign tap_wd = (rate == 3'h0) ? 1'b1 :
        (presc_r[rate - 3'h1] && !presc_inc[rate - 3'h1]);
    assign cnt_tick = owner_wdog ? edge_seen : (edge_seen && tap_cnt);
    assign wd_tick = owner_wdog ? (WDOG_TICK_I && tap_wd) : WDOG_TICK_I;

    // Next-state logic for bus, configuration, prescaler, counter and watchdog.
    always_comb begin
        wr_pend_nxt = addr_ok && HWRITE_I;
        wr_addr_nxt = addr_ok ? HADDR_I[spt_pkg::ADDR_W-1:0] : wr_addr_r;
        rdata_nxt = rdata_r;
        cfg_nxt = cfg_r;
        cnt_nxt = cnt_r;
        presc_nxt = presc_r;
        wdog_nxt = wdog_r;
        wdog_en_nxt = wdog_en_r;
        wdog_rst_nxt = wdog_rst_r;
        ovf_nxt = 1'b0;
        phase_nxt = phase_r + 2'h1;
        // Sampling only on the two phases slows the pin but hides glitches.
        samp_nxt = ((phase_r == spt_pkg::PHASE_TWO) || (phase_r == spt_pkg::PHASE_FOUR)) ?
            ext_level : samp_r;
        src_prev_nxt = cfg_r[spt_pkg::CFG_SRC_BIT] ? samp_r : src_prev_r;
        // The prescaler advances for whichever unit owns it.
        if (owner_wdog ? WDOG_TICK_I : edge_seen) begin
            presc_nxt = presc_inc;
        end
        if (cnt_tick) begin
            cnt_nxt = cnt_r + 8'h01;
            ovf_nxt = (cnt_r == 8'hFF);
        end
        if (wdog_en_r && wd_tick) begin
            wdog_nxt = wdog_r + {{(WDOG_W-1){1'b0}}, 1'b1};
            if (&wdog_r) begin
                wdog_rst_nxt = 1'b1;
            end
        end
        // Read data; the prescaler has no read path at all.
        if (addr_ok && !HWRITE_I) begin
            case (HADDR_I[spt_pkg::ADDR_W-1:0])
                spt_pkg::ADDR_CONFIG: rdata_nxt = {24'h000000, cfg_r};
                spt_pkg::ADDR_COUNT: rdata_nxt = {24'h000000, cnt_r};
                spt_pkg::ADDR_WDOG_STATUS: rdata_nxt = {30'h00000000, wdog_rst_r, wdog_en_r};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
        // Data-phase writes; a counter write wins over a count event.
        if (wr_pend_r) begin
            case (wr_addr_r)
                spt_pkg::ADDR_CONFIG: cfg_nxt = HWDATA_I[7:0];
                spt_pkg::ADDR_COUNT: cnt_nxt = HWDATA_I[7:0];
                spt_pkg::ADDR_WDOG_STATUS: begin
                    wdog_en_nxt = HWDATA_I[0];
                    wdog_rst_nxt = wdog_rst_r && !HWDATA_I[1];
                end
                default: cnt_nxt = cnt_nxt;
            endcase
        end
        if (cnt_wr && !owner_wdog) begin
            presc_nxt = 8'h00;
        end
        if (wd_clr) begin
            wdog_nxt = '0;
            if (owner_wdog) begin
                presc_nxt = 8'h00;
            end
        end
    end

    // Register stage for all state above except the two input synchronizer flops.
    always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
            rdata_r <= 32'h00000000;
            cfg_r <= spt_pkg::CFG_RESET;
            cnt_r <= 8'h00;
            presc_r <= 8'h00;
            wdog_r <= '0;
            wdog_en_r <= spt_pkg::WDOG_ENABLE_RESET[0];
            wdog_rst_r <= 1'b0;
            ovf_r <= 1'b0;
            phase_r <= 2'h0;
            // Matching the idle pin level under the reset polarity avoids a false edge.
            samp_r <= spt_pkg::CFG_RESET[spt_pkg::CFG_EDGE_BIT];
            src_prev_r <= spt_pkg::CFG_RESET[spt_pkg::CFG_EDGE_BIT];
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            rdata_r <= rdata_nxt;
            cfg_r <= cfg_nxt;
            cnt_r <= cnt_nxt;
            presc_r <= presc_nxt;
            wdog_r <= wdog_nxt;
            wdog_en_r <= wdog_en_nxt;
            wdog_rst_r <= wdog_rst_nxt;
            ovf_r <= ovf_nxt;
            phase_r <= phase_nxt;
            samp_r <= samp_nxt;
            src_prev_r <= src_prev_nxt;
        end
    end

    // Data, count and status outputs come straight from flops; HREADYOUT_O and HRESP_O are tied, so the slave never waits and never errors.
    assign HRDATA_O = rdata_r;
    assign HREADYOUT_O = RESETN_I | 1'b1;
    assign HRESP_O = 1'b0;
    assign COUNT_O = cnt_r;
    assign OVERFLOW_O = ovf_r;
    assign WDOG_RESET_O = wdog_rst_r;

    // Checks on the prescaler sharing and clearing, input sampling and the internal count source.
    AST_CNT_WR_CLR: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        (cnt_wr && !owner_wdog) |=> (presc_r == 8'h00)) else $error("Counter write kept prescaler.");
    AST_CNT_WR_OWN: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        (cnt_wr) |=> (owner_wdog == $past(owner_wdog))) else $error("Counter write moved owner.");
    AST_WD_CLR: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        (wd_clr && owner_wdog) |=> (presc_r == 8'h00 && wdog_r == '0)) else $error("Clear failed.");
    AST_WD_UNDIV: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        (!owner_wdog && WDOG_TICK_I) |-> wd_tick) else $error("Watchdog divided without owner.");
    AST_CNT_UNDIV: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        (owner_wdog && edge_seen) |-> cnt_tick) else $error("Counter divided without owner.");
    AST_SAMPLE: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        (phase_r == spt_pkg::PHASE_FOUR) |=> (samp_r == $past(ext_level))) else $error("Bad sample.");
    AST_HOLD: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        (phase_r == 2'h0) |=> $stable(samp_r)) else $error("Sample off phase.");
    AST_INT_SRC: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        (!cfg_r[spt_pkg::CFG_SRC_BIT] && !instr_tick) |-> !cnt_tick) else $error("Stray count.");
    AST_RATE0: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        (!owner_wdog && rate == 3'h0 && edge_seen && !cnt_wr && presc_r[0]) |-> cnt_tick)
        else $error("Ratio two wrong.");
    COV_OVF: cover property (@(posedge REF_CLK_I) disable iff (!RESETN_I) OVERFLOW_O);
    COV_WDRST: cover property (@(posedge REF_CLK_I) disable iff (!RESETN_I) $rose(wdog_rst_r));
    COV_EXT: cover property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
        cfg_r[spt_pkg::CFG_SRC_BIT] && cnt_tick);
endmodule
`default_nettype wire
